// File: hdl/rx_cfg_pkg.sv
// ----------------------------------------------------------------------------
// Summary of operation
// - Pre-sync loop gains apply until sync is detected, then post-sync choices apply.
// - Post-sync integral field 0 keeps pre-sync gain; 1 selects half base gain.
// - Post-sync proportional field at bit 2, reset 1; 1 selects base gain.
// - Rate offset limit resets 00 (off); 01/10/11 clamp 3.125/6.25/12.5 percent.
// - Digital ceiling bits 7:6, reset 00; n forbids the n highest digital gains.
// - Front amplifier ceiling bits 5:3, reset 000; codes 1-7 cap gain lower.
// - Amplitude target bits 2:0, reset 011; codes map 24 to 42 dB.
// - Absolute sense threshold is signed dB relative to the amplitude target.
// ----------------------------------------------------------------------------
package rx_cfg_pkg;

  // --------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // --------------------------------------------------------------------------
  localparam logic [7:0] BSYNC_IDX = 8'h10;
  localparam logic [7:0] SENSE_IDX = 8'h11;
  localparam logic [7:0] STAT_IDX  = 8'h12;
  localparam logic [7:0] AGC_IDX   = 8'h1B;

  // --------------------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------------------
  localparam int PRE_KI_LSB  = 6;
  localparam int PRE_KP_LSB  = 4;
  localparam int POST_KI_BIT = 3;
  localparam int POST_KP_BIT = 2;
  localparam int LIMIT_LSB   = 0;
  localparam int DCEIL_LSB   = 6;
  localparam int FCEIL_LSB   = 3;
  localparam int TARGET_LSB  = 0;

  localparam logic [7:0] BSYNC_RST = 8'h6C;
  localparam logic [7:0] AGC_RST   = 8'h03;
  localparam logic [3:0] SENSE_RST = 4'h0;
  localparam logic [3:0] SENSE_OFF = 4'h8;

  localparam logic [3:0] KI_HALF_POST = 4'h1;
  localparam logic [2:0] KP_POST      = 3'h1;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_NS        = 50;
  localparam int AGC_UPDATE_NS = 1600;
  localparam int AGC_UPDATE_CYC = (AGC_UPDATE_NS / CLK_NS < 1) ? 1 : AGC_UPDATE_NS / CLK_NS;
  localparam logic [7:0] AGC_HYST_DB = 8'h02;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic {PRE_SYNC = 1'b0, POST_SYNC = 1'b1} sync_phase_e;

  typedef struct packed {
    logic [3:0] ki_half;
    logic [2:0] kp;
  } loop_gain_s;

  function automatic logic [7:0] target_db(input logic [2:0] code);
    case (code)
      3'h0:    target_db = 8'h18;
      3'h1:    target_db = 8'h1B;
      3'h2:    target_db = 8'h1E;
      3'h3:    target_db = 8'h21;
      3'h4:    target_db = 8'h24;
      3'h5:    target_db = 8'h26;
      3'h6:    target_db = 8'h28;
      default: target_db = 8'h2A;
    endcase
  endfunction : target_db

endpackage : rx_cfg_pkg

// File: hdl/gain_stepper.sv
`timescale 1ns/1ps
module gain_stepper
  import rx_cfg_pkg::*;
#(
  parameter int PERIOD = AGC_UPDATE_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] amp_db,
  input  wire logic [7:0] goal_db,
  input  wire logic [2:0] front_max,
  input  wire logic [2:0] digital_max,
  output logic      [2:0] front_reg,
  output logic      [2:0] digital_reg
);

  // --------------------------------------------------------------------------
  // Update tick
  // --------------------------------------------------------------------------
  logic [15:0] tick_cnt_reg;
  logic [15:0] tick_cnt_next;
  wire         tick = (tick_cnt_reg == 16'(PERIOD - 1));

  assign tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;

  // --------------------------------------------------------------------------
  // Step decision
  // --------------------------------------------------------------------------
  wire [8:0] upper   = {1'b0, goal_db} + {1'b0, AGC_HYST_DB};
  wire       too_hot = {1'b0, amp_db} > upper;
  wire       too_low = amp_db < goal_db;
  wire       dig_dn  = tick && too_hot && (digital_reg != 3'h0);
  wire       frt_dn  = tick && too_hot && (digital_reg == 3'h0) && (front_reg != 3'h0);
  wire       frt_up  = tick && too_low && (front_reg < front_max);
  wire       dig_up  = tick && too_low && (front_reg >= front_max) && (digital_reg < digital_max);

  wire [2:0] front_step   = frt_dn ? front_reg - 3'h1 : (frt_up ? front_reg + 3'h1 : front_reg);
  wire [2:0] digital_step = dig_dn ? digital_reg - 3'h1 : (dig_up ? digital_reg + 3'h1 : digital_reg);
  wire [2:0] front_next   = (front_step > front_max) ? front_max : front_step;
  wire [2:0] digital_next = (digital_step > digital_max) ? digital_max : digital_step;

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_reg <= 16'h0000;
      front_reg    <= 3'h0;
      digital_reg  <= 3'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      front_reg    <= front_next;
      digital_reg  <= digital_next;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_front_cap: assert property (@(posedge clk) disable iff (rst) ##1 front_reg <= $past(front_max))
    else $error("front gain above ceiling");
  a_digital_cap: assert property (@(posedge clk) disable iff (rst) ##1 digital_reg <= $past(digital_max))
    else $error("digital gain above ceiling");
  a_hot_step_down: assert property (@(posedge clk) disable iff (rst)
    (!rst && tick && too_hot && digital_reg != 3'h0 && digital_reg <= digital_max) |=>
      digital_reg == $past(digital_reg) - 3'h1)
    else $error("digital gain not reduced on high amplitude");
  a_idle_hold: assert property (@(posedge clk) disable iff (rst)
    (!tick && front_reg <= front_max && digital_reg <= digital_max) |=> $stable(front_reg) && $stable(digital_reg))
    else $error("gain moved between update ticks");

endmodule : gain_stepper

// File: hdl/rx_gain_cfg.sv
`timescale 1ns/1ps
module rx_gain_cfg
  import rx_cfg_pkg::*;
#(
  parameter int GAIN_STEPS = 8,
  parameter int PERIOD     = AGC_UPDATE_CYC
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        SYNC_FOUND,
  input  wire logic        RX_ON,
  input  wire logic [7:0]  AMP_DB,
  output loop_gain_s       LOOP_GAIN,
  output logic             RATE_COMP_EN,
  output logic      [1:0]  RATE_LIMIT,
  output logic      [2:0]  FRONT_GAIN,
  output logic      [2:0]  DIGITAL_GAIN,
  output logic             CARRIER_SENSE
);

  // --------------------------------------------------------------------------
  // Bus address phase capture
  // --------------------------------------------------------------------------
  logic        wr_pend_reg;
  logic [7:0]  wr_idx_reg;
  logic [7:0]  bsync_reg;
  logic [7:0]  agc_reg;
  logic [3:0]  sense_reg;
  sync_phase_e phase_reg;
  sync_phase_e phase_next;
  logic [31:0] rd_word;
  loop_gain_s  gain_next;
  logic        sense_next;

  wire        take    = HSEL && HREADY && HTRANS[1];
  wire        in_map  = (HADDR[31:10] == 22'h00_0000) && (HADDR[1:0] == 2'b00) && (HSIZE == 3'b010);
  wire [7:0]  idx     = HADDR[9:2];
  wire        do_wr   = wr_pend_reg;
  wire [7:0]  wbyte   = HWDATA[7:0];

  always_comb begin
    rd_word = 32'h0000_0000;
    if (in_map) begin
      case (idx)
        BSYNC_IDX: rd_word = {24'h00_0000, bsync_reg};
        AGC_IDX:   rd_word = {24'h00_0000, agc_reg};
        SENSE_IDX: rd_word = {28'h000_0000, sense_reg};
        STAT_IDX:  rd_word = {22'h00_0000, CARRIER_SENSE, RATE_COMP_EN, DIGITAL_GAIN, FRONT_GAIN,
                              LOOP_GAIN.ki_half != KI_HALF_POST && phase_reg == POST_SYNC, phase_reg};
        default:   rd_word = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
      HRDATA      <= 32'h0000_0000;
      HREADYOUT   <= 1'b1;
      HRESP       <= 1'b0;
    end else begin
      wr_pend_reg <= take && HWRITE && in_map;
      wr_idx_reg  <= idx;
      HRDATA      <= (take && !HWRITE) ? rd_word : 32'h0000_0000;
      HREADYOUT   <= 1'b1;
      HRESP       <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      bsync_reg <= BSYNC_RST;
      agc_reg   <= AGC_RST;
      sense_reg <= SENSE_RST;
    end else if (do_wr) begin
      if (wr_idx_reg == BSYNC_IDX) bsync_reg <= wbyte;
      if (wr_idx_reg == AGC_IDX)   agc_reg   <= wbyte;
      if (wr_idx_reg == SENSE_IDX) sense_reg <= HWDATA[3:0];
    end
  end

  wire [1:0] pre_ki   = bsync_reg[PRE_KI_LSB +: 2];
  wire [1:0] pre_kp   = bsync_reg[PRE_KP_LSB +: 2];
  wire       post_ki  = bsync_reg[POST_KI_BIT];
  wire       post_kp  = bsync_reg[POST_KP_BIT];
  wire [1:0] limit    = bsync_reg[LIMIT_LSB +: 2];
  wire [1:0] dceil    = agc_reg[DCEIL_LSB +: 2];
  wire [2:0] fceil    = agc_reg[FCEIL_LSB +: 3];
  wire [2:0] tcode    = agc_reg[TARGET_LSB +: 3];
  wire [7:0] goal     = target_db(tcode);

  // --------------------------------------------------------------------------
  // Clock-recovery gain selection
  // --------------------------------------------------------------------------
  assign phase_next = !RX_ON ? PRE_SYNC : (SYNC_FOUND ? POST_SYNC : phase_reg);

  wire [3:0] ki_pre  = {1'b0, pre_ki, 1'b0} + 4'h2;
  wire [2:0] kp_pre  = {1'b0, pre_kp} + 3'h1;

  always_comb begin
    gain_next.ki_half = ki_pre;
    gain_next.kp      = kp_pre;
    case (phase_reg)
      PRE_SYNC: begin
        gain_next.ki_half = ki_pre;
        gain_next.kp      = kp_pre;
      end
      POST_SYNC: begin
        gain_next.ki_half = post_ki ? KI_HALF_POST : ki_pre;
        gain_next.kp      = post_kp ? KP_POST : kp_pre;
      end
      default: begin
        gain_next.ki_half = ki_pre;
        gain_next.kp      = kp_pre;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Carrier sense against the target
  // --------------------------------------------------------------------------
  wire signed [9:0] sense_lvl = $signed({2'b00, goal}) + 10'(signed'(sense_reg));
  assign sense_next = (sense_reg != SENSE_OFF) && ($signed({2'b00, AMP_DB}) >= sense_lvl);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      phase_reg     <= PRE_SYNC;
      LOOP_GAIN     <= '0;
      RATE_COMP_EN  <= 1'b0;
      RATE_LIMIT    <= 2'b00;
      CARRIER_SENSE <= 1'b0;
    end else begin
      phase_reg     <= phase_next;
      LOOP_GAIN     <= gain_next;
      RATE_COMP_EN  <= (limit != 2'b00);
      RATE_LIMIT    <= limit;
      CARRIER_SENSE <= sense_next;
    end
  end

  // --------------------------------------------------------------------------
  // Gain loop
  // --------------------------------------------------------------------------
  gain_stepper #(
    .PERIOD (PERIOD)
  ) u_stepper (
    .clk         (CLK),
    .rst         (SYS_RST),
    .amp_db      (AMP_DB),
    .goal_db     (goal),
    .front_max   (3'(7) - fceil),
    .digital_max (3'(GAIN_STEPS - 1) - {1'b0, dceil}),
    .front_reg   (FRONT_GAIN),
    .digital_reg (DIGITAL_GAIN)
  );

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_sync_seen;
    RX_ON && SYNC_FOUND;
  endsequence

  sequence s_post_held;
    RX_ON [*2];
  endsequence

  a_pre_until_sync: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!SYS_RST && phase_reg == PRE_SYNC && !SYNC_FOUND) |=> LOOP_GAIN.kp == $past(kp_pre))
    else $error("pre-sync proportional gain not applied");
  a_post_ki_half: assert property (@(posedge CLK) disable iff (SYS_RST)
    (s_sync_seen ##0 s_post_held ##0 post_ki && $stable(bsync_reg)) |=> LOOP_GAIN.ki_half == KI_HALF_POST)
    else $error("post-sync integral gain not halved");
  a_post_kp_keep: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!SYS_RST && phase_reg == POST_SYNC && !post_kp) |=> LOOP_GAIN.kp == $past(kp_pre))
    else $error("post-sync proportional gain not kept");
  a_rate_off: assert property (@(posedge CLK) disable iff (SYS_RST)
    (limit == 2'b00) ##1 (limit == 2'b00) |-> !RATE_COMP_EN)
    else $error("rate compensation active with zero limit");
  a_reset_agc: assert property (@(posedge CLK)
    $fell(SYS_RST) |-> agc_reg == AGC_RST && bsync_reg == BSYNC_RST)
    else $error("reset value wrong");
  a_sense_track: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!SYS_RST && sense_reg == 4'h0 && AMP_DB == goal) |=> CARRIER_SENSE)
    else $error("carrier sense missed at target");
  a_bus_okay: assert property (@(posedge CLK) disable iff (SYS_RST)
    take |=> HREADYOUT && !HRESP)
    else $error("bus answer not ready and okay");

endmodule : rx_gain_cfg

// File: verification/rx_gain_cfg_bench.sv
`timescale 1ns/1ps
module rx_gain_cfg_bench;
  import rx_cfg_pkg::*;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic        clk, sys_rst, hsel, hwrite, sync_found, rx_on;
  logic        hreadyout, hresp, rate_comp_en, carrier_sense;
  logic [1:0]  htrans, rate_limit;
  logic [2:0]  hsize, front_gain, digital_gain;
  logic [7:0]  amp_db;
  logic [31:0] haddr, hwdata, hrdata, rd;
  loop_gain_s  loop_gain;
  int          err_total, samples_checked;

  always #25 clk = ~clk;

  rx_gain_cfg #(.GAIN_STEPS(8), .PERIOD(4)) dut (
    .CLK(clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .SYNC_FOUND(sync_found), .RX_ON(rx_on), .AMP_DB(amp_db), .LOOP_GAIN(loop_gain),
    .RATE_COMP_EN(rate_comp_en), .RATE_LIMIT(rate_limit), .FRONT_GAIN(front_gain),
    .DIGITAL_GAIN(digital_gain), .CARRIER_SENSE(carrier_sense)
  );

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task test_done;
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      if (n == 50) begin
        err_total++;
        test_done();
      end
      @(posedge clk);
      n++;
    end
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {22'h00_0000, idx, 2'b00};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk("bus response", 32'h0000_0000, {31'h0, hresp});
  endtask : xfer

  task automatic sense_at(input logic [7:0] a, input logic exp);
    amp_db <= a;
    repeat (3) @(posedge clk);
    chk("carrier sense", {31'h0, exp}, {31'h0, carrier_sense});
  endtask : sense_at

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    xfer(1'b0, BSYNC_IDX, 32'h0000_0000);
    chk("sync config reset", 32'h0000_006C, rd);
    xfer(1'b0, AGC_IDX, 32'h0000_0000);
    chk("gain control reset", 32'h0000_0003, rd);
    xfer(1'b0, SENSE_IDX, 32'h0000_0000);
    chk("sense threshold reset", 32'h0000_0000, rd);
    xfer(1'b0, 8'h05, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
    chk("pre-sync gain", {25'h0, 4'h4, 3'h3}, {25'h0, loop_gain});
    chk("rate comp", 32'h0000_0000, {29'h0, rate_comp_en, rate_limit});
  endtask : t_reset

  task automatic t_loop;
    logic [7:0] tbl [4] = '{8'hC1, 8'hBA, 8'h17, 8'h6C};
    logic [3:0] ki;
    logic [2:0] kp;
    for (int i = 0; i < 4; i++) begin
      rx_on      <= 1'b0;
      sync_found <= 1'b0;
      xfer(1'b1, BSYNC_IDX, {24'h00_0000, tbl[i]});
      ki = 4'h2 * ({2'b00, tbl[i][7:6]} + 4'h1);
      kp = 3'h1 + {1'b0, tbl[i][5:4]};
      repeat (3) @(posedge clk);
      chk("pre-sync gain", {25'h0, ki, kp}, {25'h0, loop_gain});
      chk("rate comp", {29'h0, tbl[i][1:0] != 2'b00, tbl[i][1:0]}, {29'h0, rate_comp_en, rate_limit});
      rx_on      <= 1'b1;
      sync_found <= 1'b1;
      repeat (3) @(posedge clk);
      sync_found <= 1'b0;
      chk("post-sync gain", {25'h0, (tbl[i][3] ? 4'h1 : ki), (tbl[i][2] ? 3'h1 : kp)}, {25'h0, loop_gain});
    end
  endtask : t_loop

  task automatic t_agc;
    amp_db <= 8'h00;
    xfer(1'b1, AGC_IDX, 32'h0000_00AB);
    repeat (100) @(posedge clk);
    chk("front gain", 32'h0000_0002, {29'h0, front_gain});
    chk("digital gain", 32'h0000_0005, {29'h0, digital_gain});
    xfer(1'b0, STAT_IDX, 32'h0000_0000);
    chk("status word", 32'h0000_00A9, rd);
    amp_db <= 8'hC8;
    repeat (100) @(posedge clk);
    chk("front gain", 32'h0000_0000, {29'h0, front_gain});
    chk("digital gain", 32'h0000_0000, {29'h0, digital_gain});
    xfer(1'b0, STAT_IDX, 32'h0000_0000);
    chk("status word", 32'h0000_0201, rd);
    amp_db <= 8'h00;
    xfer(1'b1, AGC_IDX, 32'h0000_0000);
    repeat (100) @(posedge clk);
    chk("front gain", 32'h0000_0007, {29'h0, front_gain});
    chk("digital gain", 32'h0000_0007, {29'h0, digital_gain});
    xfer(1'b1, AGC_IDX, 32'h0000_00FF);
    repeat (2) @(posedge clk);
    chk("front gain", 32'h0000_0000, {29'h0, front_gain});
    chk("digital gain", 32'h0000_0004, {29'h0, digital_gain});
    xfer(1'b0, AGC_IDX, 32'h0000_0000);
    chk("gain control readback", 32'h0000_00FF, rd);
  endtask : t_agc

  task automatic t_sense;
    logic [7:0] tgt [8] = '{8'h18, 8'h1B, 8'h1E, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2A};
    xfer(1'b1, SENSE_IDX, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, AGC_IDX, 32'(i));
      sense_at(tgt[i], 1'b1);
      sense_at(tgt[i] - 8'h01, 1'b0);
    end
    xfer(1'b1, AGC_IDX, 32'h0000_0003);
    xfer(1'b1, SENSE_IDX, 32'h0000_000F);
    sense_at(8'h20, 1'b1);
    sense_at(8'h1F, 1'b0);
    xfer(1'b1, SENSE_IDX, 32'h0000_0007);
    sense_at(8'h28, 1'b1);
    sense_at(8'h27, 1'b0);
    xfer(1'b1, SENSE_IDX, 32'h0000_0008);
    sense_at(8'hFF, 1'b0);
  endtask : t_sense

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    clk             = 1'b0;
    sys_rst         = 1'b1;
    hsel            = 1'b0;
    haddr           = 32'h0000_0000;
    htrans          = 2'b00;
    hwrite          = 1'b0;
    hsize           = 3'b010;
    hwdata          = 32'h0000_0000;
    sync_found      = 1'b0;
    rx_on           = 1'b1;
    amp_db          = 8'h00;
    err_total       = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_loop();
    t_agc();
    t_sense();
    test_done();
  end
endmodule : rx_gain_cfg_bench
